// file: tb_vref_ctrl.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_vref_ctrl;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc_i = 0;
  logic stb_i = 0;
  logic we_i = 0;
  logic [15:0] adr_i = 16'h0;
  logic [3:0] sel_i = 4'hf;
  logic [3:0] sel_v = 4'hf;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, q;
  logic ack_o, ref_enable_o, power_down_o, ref_pin_output_enable_o;
  logic ref_range_select_o, ref_source_select_o;
  logic [3:0] ref_level_code_o;
  logic [6:0] ladder_tap_o, e;
  int num_errors = 0;
  int n_checks = 0;
  vref_ctrl dut (.*);
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  task finish_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one classic cycle, waits for ack, then one idle cycle
  task bus(input logic [15:0] a, input logic [31:0] d, input logic w);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= sel_v;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (ack_o !== 1'b1) begin
      num_errors++;
      finish_test();
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task rd(input logic [15:0] a, input logic [31:0] x);
    bus(a, 32'h0, 1'b0);
    `CHK("read", x, q)
  endtask
  task t_reset();
    `CHK("pd", 1'b1, power_down_o)
    `CHK("en", 1'b0, ref_enable_o)
    rd(16'h9800, 32'h0);
  endtask
  task t_rerst();
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK("tap", 7'h00, ladder_tap_o)
    t_reset();
  endtask
  task t_all();
    bus(16'h9800, 32'hffff_ffff, 1'b1);
    `CHK("en", 1'b1, ref_enable_o)
    rd(16'h9800, 32'h0000_807f);
    `CHK("tap", 7'h3c, ladder_tap_o)
  endtask
  task t_onoff();
    bus(16'h9804, 32'h0000_8000, 1'b1);
    rd(16'h9800, 32'h0000_007f);
    `CHK("pd", 1'b1, power_down_o)
    `CHK("tap", 7'h00, ladder_tap_o)
    `CHK("oe", 1'b1, ref_pin_output_enable_o)
    bus(16'h9808, 32'h0000_8000, 1'b1);
    rd(16'h9800, 32'h0000_807f);
  endtask
  task t_inv();
    bus(16'h980c, 32'h0000_0070, 1'b1);
    rd(16'h980c, 32'h0000_800f);
    `CHK("oe", 1'b0, ref_pin_output_enable_o)
    `CHK("src", 1'b0, ref_source_select_o)
  endtask
  task t_levels();
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 16; c++) begin
        bus(16'h9800, 32'h8010 | (r << 5) | c, 1'b1);
        e = r ? 7'(c * 4) : 7'(24 + c * 3);
        `CHK("tap", e, ladder_tap_o)
        `CHK("rng", 1'(r), ref_range_select_o)
        `CHK("lvl", 4'(c), ref_level_code_o)
        `CHK("src", 1'b1, ref_source_select_o)
      end
    end
  endtask
  task t_unmapped();
    bus(16'h9810, 32'hffff_ffff, 1'b1);
    bus(16'h9802, 32'h0000_0000, 1'b1);
    rd(16'h9810, 32'h0);
    rd(16'h9802, 32'h0);
    rd(16'h9800, 32'h0000_803f);
    sel_v = 4'h1;
    bus(16'h9800, 32'h0000_0000, 1'b1);
    sel_v = 4'hf;
    rd(16'h9800, 32'h0000_8000);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_all();
    t_onoff();
    t_inv();
    t_levels();
    t_unmapped();
    t_rerst();
    finish_test();
  end
endmodule // tb_vref_ctrl

// file: vref_ctrl.sv
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`include "vref_regs.svh"
module vref_ctrl (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // analog ladder controls
  output logic ref_enable_o,
  output logic power_down_o,
  output logic ref_pin_output_enable_o,
  output logic ref_range_select_o,
  output logic ref_source_select_o,
  output logic [3:0] ref_level_code_o,
  output logic [6:0] ladder_tap_o
);
  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic hit, wr, ack;
  vref_pkg::vref_op_t op;

  vref_wb_slave #(.ADDR_W(16)) u_bus (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .ack_o(ack),
    .hit_o(hit),
    .wr_o(wr),
    .op_o(op)
  );

  // ----------------------------------------
  // control register
  // ----------------------------------------
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] wmask, dmask;
  logic [31:0] dat_q, dat_d;
  logic ack_q;

  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  always_comb begin
    wmask = lane_mask(sel_i) & `VREF_CTRL_MASK; // RULE8
    dmask = dat_i & wmask;
    ctrl_d = ctrl_q;
    if (wr) begin
      case (op)
        vref_pkg::VREF_OP_WRITE: ctrl_d = (ctrl_q & ~wmask) | dmask; // RULE1
        vref_pkg::VREF_OP_CLR: ctrl_d = ctrl_q & ~dmask; // RULE11
        vref_pkg::VREF_OP_SET: ctrl_d = ctrl_q | dmask; // RULE11
        vref_pkg::VREF_OP_INV: ctrl_d = ctrl_q ^ dmask; // RULE11
        default: ctrl_d = ctrl_q;
      endcase
    end
    dat_d = dat_q;
    if (cyc_i && stb_i && !we_i && !ack && !ack_q) begin
      dat_d = hit ? (ctrl_q & `VREF_CTRL_MASK) : 32'h0000_0000; // RULE8
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `VREF_CTRL_RESET;
      dat_q <= 32'h0000_0000;
      ack_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      dat_q <= dat_d;
      ack_q <= ack;
    end
  end

  assign dat_o = dat_q;
  assign ack_o = ack;

  // ----------------------------------------
  // ladder outputs
  // ----------------------------------------
  logic [6:0] tap_d, tap_q;
  logic pd_d, pd_q;

  vref_ladder_ctl u_ladder (
    .enable_i(ctrl_q[`VREF_ENABLE_BIT]),
    .range_i(ctrl_q[`VREF_RANGE_BIT]),
    .level_i(ctrl_q[`VREF_LEVEL_MSB:`VREF_LEVEL_LSB]),
    .tap_o(tap_d),
    .power_down_o(pd_d)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tap_q <= `VREF_TAP_OFF;
      pd_q <= `VREF_PD_RESET;
    end else begin
      tap_q <= tap_d; // RULE12
      pd_q <= pd_d; // RULE2
    end
  end

  assign ladder_tap_o = tap_q;
  assign power_down_o = pd_q;
  assign ref_enable_o = ctrl_q[`VREF_ENABLE_BIT]; // RULE1
  assign ref_pin_output_enable_o = ctrl_q[`VREF_PIN_OE_BIT]; // RULE3
  assign ref_range_select_o = ctrl_q[`VREF_RANGE_BIT]; // RULE4
  assign ref_source_select_o = ctrl_q[`VREF_SOURCE_BIT]; // RULE5
  assign ref_level_code_o = ctrl_q[`VREF_LEVEL_MSB:`VREF_LEVEL_LSB]; // RULE12
endmodule // vref_ctrl

// file: vref_ctrl_assertions.sv
`timescale 1ns/1ps
module vref_ctrl_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic ref_enable_o,
  input wire logic power_down_o,
  input wire logic ref_pin_output_enable_o,
  input wire logic ref_range_select_o,
  input wire logic ref_source_select_o,
  input wire logic [3:0] ref_level_code_o,
  input wire logic [6:0] ladder_tap_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire wr_c = cyc_i && stb_i && we_i && !ack_o && adr_i == 16'h9800;
  wire set_c = cyc_i && stb_i && we_i && !ack_o && adr_i == 16'h9808;
  AST_ACK: assert property ($rose(stb_i) && cyc_i |=> ack_o ##1 !ack_o)
    else $error("ack");
  AST_EN: assert property (wr_c && sel_i[1] |=> ref_enable_o == $past(dat_i[15]))
    else $error("enable");
  AST_FLD: assert property (wr_c && sel_i[0] |=> {ref_pin_output_enable_o,
    ref_range_select_o, ref_source_select_o, ref_level_code_o} == $past(dat_i[6:0]))
    else $error("fields");
  AST_SET: assert property (set_c && sel_i[0] |=>
    ref_level_code_o == ($past(ref_level_code_o) | $past(dat_i[3:0]))) else $error("set");
  AST_PD: assert property (power_down_o == !$past(ref_enable_o)) else $error("pd");
  AST_OFF: assert property (power_down_o |-> ladder_tap_o == 7'h00) else $error("off");
  AST_HI: assert property (!power_down_o && $past(ref_range_select_o) |->
    ladder_tap_o == {1'b0, $past(ref_level_code_o), 2'b00}) else $error("hi");
  AST_LO: assert property (!power_down_o && !$past(ref_range_select_o) |->
    ladder_tap_o == 7'h18 + {3'h0, $past(ref_level_code_o)} * 7'h03) else $error("lo");
  AST_RSV: assert property (ack_o |-> dat_o[31:16] == 16'h0 && dat_o[14:7] == 8'h0)
    else $error("rsv");
endmodule // vref_ctrl_assertions
bind vref_ctrl vref_ctrl_assertions chk (.*);

// file: vref_ladder_ctl.sv
`timescale 1ns/1ps
`include "vref_regs.svh"
// maps control fields to ladder select lines
module vref_ladder_ctl (
  // control fields
  input wire logic enable_i,
  input wire logic range_i,
  input wire logic [3:0] level_i,
  // ladder tap in units of span/96 (lcm of 24 and 32 base steps)
  output logic [6:0] tap_o,
  output logic power_down_o
);
  function automatic logic [6:0] tap_of(input logic rng, input logic [3:0] code);
    logic [6:0] t;
    t = 7'h00;
    if (rng) begin
      t = 7'({3'h0, code} * `VREF_SPAN1_STEP); // RULE6
    end else begin
      t = `VREF_SPAN0_BASE + 7'({3'h0, code} * `VREF_SPAN0_STEP); // RULE7
    end
    return t;
  endfunction

  always_comb begin
    power_down_o = ~enable_i; // RULE2
    tap_o = enable_i ? tap_of(range_i, level_i) : `VREF_TAP_OFF; // RULE4
  end
endmodule // vref_ladder_ctl

// file: vref_pkg.sv
package vref_pkg;
  typedef enum logic [1:0] {
    VREF_OP_WRITE = 2'b00,
    VREF_OP_CLR = 2'b01,
    VREF_OP_SET = 2'b10,
    VREF_OP_INV = 2'b11
  } vref_op_t;

  typedef enum logic [1:0] {
    VREF_BUS_IDLE = 2'b00,
    VREF_BUS_ACK = 2'b01,
    VREF_BUS_HOLD = 2'b10
  } vref_bus_state_t;
endpackage

// file: vref_regs.svh
// Operation
// [RULE1] bit 15 enables the reference; writing it leaves other fields unchanged
// [RULE2] enable clear holds module off and ladder in no-current power-down
// [RULE3] bit 6 connects the reference to the dedicated output pin
// [RULE4] bit 5 picks range: 0..0.67 in 1/24 steps, else 0.25..0.75 in 1/32
// [RULE5] bit 4 picks supply: external reference pins when set, analog rails when clear
// [RULE6] range set: reference equals code/24 times source span
// [RULE7] range clear: reference equals quarter span plus code/32 times span
// [RULE8] bits 31-16 and 14-7 ignore writes and read zero
// [RULE9] clear, set, invert aliases sit at base plus 0x4, 0x8, 0xc
// [RULE10] at 1:1 divisor software skips register access right after clearing enable
// [RULE11] alias writes clear, set or toggle bits written as one
// [RULE12] ladder controls are static outputs updated the edge after a write; here ladder_tap_o and power_down_o update one edge later
`ifndef VREF_REGS_SVH
`define VREF_REGS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define VREF_CTRL_OFFSET 16'h9800
`define VREF_CLR_OFFSET 16'h0004
`define VREF_SET_OFFSET 16'h0008
`define VREF_INV_OFFSET 16'h000c
`define VREF_CTRL_RESET 32'h0000_0000
`define VREF_CTRL_MASK 32'h0000_807f

// ----------------------------------------
// field positions
// ----------------------------------------
`define VREF_ENABLE_BIT 15
`define VREF_PIN_OE_BIT 6
`define VREF_RANGE_BIT 5
`define VREF_SOURCE_BIT 4
`define VREF_LEVEL_MSB 3
`define VREF_LEVEL_LSB 0

// ----------------------------------------
// ladder tap arithmetic
// ----------------------------------------
// taps count in span/96 units so both step sizes are whole numbers
`define VREF_SPAN0_BASE 7'h18
`define VREF_SPAN0_STEP 7'h03
`define VREF_SPAN1_STEP 7'h04
`define VREF_TAP_OFF 7'h00
`define VREF_PD_RESET 1'b1

`endif

// file: vref_wb_slave.sv
`timescale 1ns/1ps
`include "vref_regs.svh"
// classic wishbone decode: one-cycle ack, drops ack before next request
module vref_wb_slave #(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  output logic ack_o,
  // decoded request
  output logic hit_o,
  output logic wr_o,
  output vref_pkg::vref_op_t op_o
);
  if (ADDR_W < 16) begin : g_addr_check
    $error("address width too small");
  end

  vref_pkg::vref_bus_state_t state_q, state_d;
  logic ack_q, ack_d;
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] off;

  always_comb begin
    base = ADDR_W'(`VREF_CTRL_OFFSET);
    off = adr_i - base;
    hit_o = (adr_i[ADDR_W-1:4] == base[ADDR_W-1:4]) && (adr_i[1:0] == 2'b00);
    op_o = vref_pkg::vref_op_t'(off[3:2]); // RULE9
    wr_o = (state_q == vref_pkg::VREF_BUS_IDLE) && cyc_i && stb_i && we_i && hit_o;
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      vref_pkg::VREF_BUS_IDLE: begin
        if (cyc_i && stb_i) begin
          state_d = vref_pkg::VREF_BUS_ACK;
        end
      end
      vref_pkg::VREF_BUS_ACK: state_d = vref_pkg::VREF_BUS_HOLD;
      vref_pkg::VREF_BUS_HOLD: state_d = vref_pkg::VREF_BUS_IDLE;
      default: state_d = vref_pkg::VREF_BUS_IDLE;
    endcase
    // ack comes from its own flop so the port is registered
    ack_d = (state_d == vref_pkg::VREF_BUS_ACK);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= vref_pkg::VREF_BUS_IDLE;
      ack_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ack_q <= ack_d;
    end
  end

  assign ack_o = ack_q;
endmodule // vref_wb_slave
